// [hw/lcag_gate.sv]
// lifecycle state holder with debug and serial programming access gating
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module lcag_gate (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [7:0] NV_STATE,
  output logic NV_WR,
  output logic [7:0] NV_WDATA,
  output logic FLASH_ERASE_ALL,
  input wire logic DBG_REQ,
  output logic DBG_GRANT,
  output lcag_pkg::lcag_acc_type ACCESS,
  input wire lcag_pkg::lcag_sp_req_type SP_REQ,
  output logic SP_GRANT,
  output logic SP_REJECT
);
  lcag_pkg::lcag_lc_type lc_q, tgt, au_tgt_q;
  lcag_pkg::lcag_au_type au_q;
  lcag_pkg::lcag_acc_type acc_d, acc_q;
  logic loaded_q;
  logic [3:0] op;
  logic cmd_wr, resp_wr, resp_good;
  logic adv_ok, reg_ok, erase_ok, inj_ok, cmd_ok;
  logic [31:0] key_data_q, sdk_q, nsdk_q;
  logic [4:0] key_v_q;
  logic [31:0] lfsr_q, chal_q, au_key_q;
  logic res_ok_q, res_bad_q, res_err_q;
  logic nv_wr_q, erase_q, dbg_s1_q, dbg_s2_q;
  logic sp_grant_q, sp_reject_q;
  logic [31:0] rd_mux, rdata_q;
  // restrictiveness order; return states sit outside the forward chain
  function automatic logic [2:0] rank(input lcag_pkg::lcag_lc_type s);
    case (s)
      lcag_pkg::chip_manufacturing_state: rank = 3'h1;
      lcag_pkg::secure_dev_state: rank = 3'h2;
      lcag_pkg::nonsecure_dev_state: rank = 3'h3;
      lcag_pkg::deployed_state: rank = 3'h4;
      lcag_pkg::locked_debug_state: rank = 3'h5;
      lcag_pkg::locked_boot_state: rank = 3'h6;
      default: rank = 3'h0;
    endcase
  endfunction

  // key_v_q bits: 0 secure debug, 1 nonsecure debug, 2 return, 3 unique id, 4 hw key
  assign op = WDATA[lcag_pkg::CMD_OP_POS +: 4];
  assign tgt = lcag_pkg::lcag_lc_type'(WDATA[lcag_pkg::CMD_TGT_POS +: 8]);
  assign cmd_wr = WR && ADDR == lcag_pkg::OFS_CMD && loaded_q && au_q == lcag_pkg::AU_IDLE;
  assign resp_wr = WR && ADDR == lcag_pkg::OFS_RESP && au_q == lcag_pkg::AU_WAIT;
  assign resp_good = resp_wr && WDATA == (chal_q ^ au_key_q);

  always_comb begin
    adv_ok = 1'b0;
    reg_ok = 1'b0;
    erase_ok = 1'b0;
    inj_ok = 1'b0;
    if (cmd_wr) begin
      case (op)
        lcag_pkg::OP_ADVANCE: begin
          // forward only, and manufacturing exit waits for both identity items
          adv_ok = rank(lc_q) != 3'h0 && rank(tgt) > rank(lc_q) &&
                   (lc_q != lcag_pkg::chip_manufacturing_state || &key_v_q[4:3]);
        end
        lcag_pkg::OP_REGRESS: begin
          reg_ok = (lc_q == lcag_pkg::nonsecure_dev_state &&
                    tgt == lcag_pkg::secure_dev_state && key_v_q[0]) ||
                   (lc_q == lcag_pkg::deployed_state &&
                    tgt == lcag_pkg::nonsecure_dev_state && key_v_q[1]);
        end
        lcag_pkg::OP_ERASE: begin
          erase_ok = lc_q == lcag_pkg::nonsecure_dev_state ||
                     lc_q == lcag_pkg::deployed_state;
        end
        lcag_pkg::OP_INJ_SDK, lcag_pkg::OP_INJ_RAK: begin
          inj_ok = lc_q == lcag_pkg::secure_dev_state;
        end
        lcag_pkg::OP_INJ_NSDK: begin
          inj_ok = lc_q == lcag_pkg::nonsecure_dev_state;
        end
        lcag_pkg::OP_INJ_UID, lcag_pkg::OP_INJ_HUK: begin
          inj_ok = lc_q == lcag_pkg::chip_manufacturing_state;
        end
        default: begin
          inj_ok = 1'b0;
        end
      endcase
    end
  end
  assign cmd_ok = adv_ok || reg_ok || erase_ok || inj_ok;
  // state is read from the store once after reset; a bad code fails closed to locked boot
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lc_q <= lcag_pkg::chip_manufacturing_state;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      lc_q <= $onehot(NV_STATE) ? lcag_pkg::lcag_lc_type'(NV_STATE) :
              lcag_pkg::locked_boot_state;
    end else if (adv_ok) begin
      lc_q <= tgt;
    end else if (erase_ok) begin
      lc_q <= lcag_pkg::secure_dev_state;
    end else if (resp_good) begin
      lc_q <= au_tgt_q;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      nv_wr_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      nv_wr_q <= adv_ok || erase_ok || resp_good;
      erase_q <= erase_ok;
    end
  end
  assign NV_WR = nv_wr_q;
  assign NV_WDATA = lc_q;
  assign FLASH_ERASE_ALL = erase_q;

  // keys are staged, then committed by an inject; the return, unique id and hw keys are only flagged present
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      key_data_q <= '0;
      sdk_q <= '0;
      nsdk_q <= '0;
      key_v_q <= '0;
    end else begin
      if (WR && ADDR == lcag_pkg::OFS_KEY) begin
        key_data_q <= WDATA;
      end
      // inject op codes run in the same order as the key flag bits
      if (inj_ok) begin
        key_v_q[3'(op - lcag_pkg::OP_INJ_SDK)] <= 1'b1;
      end
      if (inj_ok && op == lcag_pkg::OP_INJ_SDK) begin
        sdk_q <= key_data_q;
      end
      if (inj_ok && op == lcag_pkg::OP_INJ_NSDK) begin
        nsdk_q <= key_data_q;
      end
    end
  end
  // free-running challenge source; unpredictable on the bus, not cryptographic
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lfsr_q <= lcag_pkg::LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      au_q <= lcag_pkg::AU_IDLE;
      au_tgt_q <= lcag_pkg::chip_manufacturing_state;
      chal_q <= '0;
      au_key_q <= '0;
    end else begin
      case (au_q)
        lcag_pkg::AU_IDLE: begin
          if (reg_ok) begin
            au_q <= lcag_pkg::AU_WAIT;
            au_tgt_q <= tgt;
            chal_q <= lfsr_q;
            au_key_q <= tgt == lcag_pkg::secure_dev_state ? sdk_q : nsdk_q;
          end
        end
        lcag_pkg::AU_WAIT: begin
          // one attempt per challenge so a replayed answer never matches twice
          if (resp_wr) begin
            au_q <= lcag_pkg::AU_IDLE;
            chal_q <= '0;
          end
        end
        default: begin
          au_q <= lcag_pkg::AU_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      res_ok_q <= 1'b0;
      res_bad_q <= 1'b0;
      res_err_q <= 1'b0;
    end else begin
      if (reg_ok) begin
        res_ok_q <= 1'b0;
        res_bad_q <= 1'b0;
      end else if (resp_wr) begin
        res_ok_q <= resp_good;
        res_bad_q <= !resp_good;
      end
      if (WR && ADDR == lcag_pkg::OFS_CMD) begin
        res_err_q <= !cmd_ok;
      end
    end
  end
  // gating waits for the stored state so the reset value never opens the debug port
  always_comb begin
    acc_d = '0;
    if (loaded_q) begin
      case (lc_q)
        lcag_pkg::chip_manufacturing_state, lcag_pkg::return_ack_state: begin
          acc_d.dbg_level = lcag_pkg::DEBUG_FULL_LEVEL;
          acc_d.sp_en = 1'b1;
        end
        lcag_pkg::secure_dev_state: begin
          acc_d.dbg_level = lcag_pkg::DEBUG_FULL_LEVEL;
          acc_d.sp_en = 1'b1;
          acc_d.sp_sec_flash = 1'b1;
          acc_d.sp_ns_flash = 1'b1;
        end
        lcag_pkg::nonsecure_dev_state: begin
          acc_d.dbg_level = lcag_pkg::DEBUG_NONSECURE_LEVEL;
          acc_d.sp_en = 1'b1;
          acc_d.sp_ns_flash = 1'b1;
        end
        lcag_pkg::deployed_state, lcag_pkg::locked_debug_state,
        lcag_pkg::return_request_state: begin
          acc_d.dbg_level = lcag_pkg::DEBUG_NONE_LEVEL;
          acc_d.sp_en = 1'b1;
        end
        default: begin
          acc_d.dbg_level = lcag_pkg::DEBUG_NONE_LEVEL;
        end
      endcase
      acc_d.dbg_conn = acc_d.dbg_level != lcag_pkg::DEBUG_NONE_LEVEL;
      acc_d.dbg_secure = acc_d.dbg_level == lcag_pkg::DEBUG_FULL_LEVEL;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end
  assign ACCESS = acc_q;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dbg_s1_q <= 1'b0;
      dbg_s2_q <= 1'b0;
    end else begin
      dbg_s1_q <= DBG_REQ;
      dbg_s2_q <= dbg_s1_q;
    end
  end
  assign DBG_GRANT = dbg_s2_q && acc_q.dbg_conn;

  // flash requests need the matching area right; non-flash ones need only sp_en
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sp_grant_q <= 1'b0;
      sp_reject_q <= 1'b0;
    end else begin
      sp_grant_q <= SP_REQ.valid && acc_q.sp_en && (!SP_REQ.flash ||
                    (SP_REQ.secure ? acc_q.sp_sec_flash : acc_q.sp_ns_flash));
      sp_reject_q <= SP_REQ.valid && !(acc_q.sp_en && (!SP_REQ.flash ||
                     (SP_REQ.secure ? acc_q.sp_sec_flash : acc_q.sp_ns_flash)));
    end
  end
  assign SP_GRANT = sp_grant_q;
  assign SP_REJECT = sp_reject_q;

  always_comb begin
    rd_mux = '0;
    case (ADDR)
      lcag_pkg::OFS_STATUS: begin
        rd_mux[lcag_pkg::ST_LC_POS +: 8] = lc_q;
        rd_mux[lcag_pkg::ST_LVL_POS +: 2] = acc_q.dbg_level;
        rd_mux[lcag_pkg::ST_KEYS_POS +: 5] = key_v_q;
        rd_mux[lcag_pkg::ST_BUSY_POS] = au_q == lcag_pkg::AU_WAIT;
        rd_mux[lcag_pkg::ST_LOADED_POS] = loaded_q;
      end
      lcag_pkg::OFS_CHAL: begin
        rd_mux = chal_q;
      end
      lcag_pkg::OFS_RESULT: begin
        rd_mux[lcag_pkg::RES_OK_POS] = res_ok_q;
        rd_mux[lcag_pkg::RES_BAD_POS] = res_bad_q;
        rd_mux[lcag_pkg::RES_ERR_POS] = res_err_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= RD ? rd_mux : '0;
    end
  end
  assign RDATA = rdata_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_full_level;
    loaded_q && lc_q == lcag_pkg::secure_dev_state |=>
      acc_q.dbg_secure && acc_q.dbg_conn && acc_q.sp_sec_flash;
  endproperty
  a_full_level: assert property (p_full_level) else $error("full access missing");
  property p_ns_level;
    loaded_q && lc_q == lcag_pkg::nonsecure_dev_state |=>
      acc_q.dbg_conn && !acc_q.dbg_secure && !acc_q.sp_sec_flash && acc_q.sp_ns_flash;
  endproperty
  a_ns_level: assert property (p_ns_level) else $error("nonsecure level wrong");
  property p_no_debug;
    lc_q inside {lcag_pkg::deployed_state, lcag_pkg::locked_debug_state,
                 lcag_pkg::locked_boot_state} |=> !acc_q.dbg_conn ##0 !DBG_GRANT;
  endproperty
  a_no_debug: assert property (p_no_debug) else $error("debug open while locked");
  property p_boot_lock;
    lc_q == lcag_pkg::locked_boot_state |=> ##1 !SP_GRANT;
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("serial grant in locked boot");
  property p_sp_flash;
    SP_GRANT && $past(SP_REQ.flash, 1) |-> $past(acc_q.sp_ns_flash || acc_q.sp_sec_flash, 1);
  endproperty
  a_sp_flash: assert property (p_sp_flash) else $error("flash grant without right");
  property p_inject;
    $rose(key_v_q[0]) || $rose(key_v_q[2]) |-> $past(lc_q) == lcag_pkg::secure_dev_state;
  endproperty
  a_inject: assert property (p_inject) else $error("key injected outside secure dev");
  property p_forward;
    adv_ok |=> rank(lc_q) > rank($past(lc_q)) && NV_WR;
  endproperty
  a_forward: assert property (p_forward) else $error("advance went backward");
  property p_challenge;
    reg_ok |=> au_q == lcag_pkg::AU_WAIT && chal_q == $past(lfsr_q);
  endproperty
  a_challenge: assert property (p_challenge) else $error("no challenge issued");
  property p_good;
    resp_good |=> lc_q == $past(au_tgt_q) ##1 acc_q.dbg_conn;
  endproperty
  a_good: assert property (p_good) else $error("good response not honoured");
  property p_bad;
    resp_wr && !resp_good |=> $stable(lc_q) && res_bad_q && !NV_WR;
  endproperty
  a_bad: assert property (p_bad) else $error("bad response changed state");
  property p_erase;
    erase_ok |=> lc_q == lcag_pkg::secure_dev_state && FLASH_ERASE_ALL;
  endproperty
  a_erase: assert property (p_erase) else $error("all-erase incomplete");
  property p_cm_exit;
    loaded_q && $past(loaded_q) && $past(lc_q) == lcag_pkg::chip_manufacturing_state &&
      lc_q != lcag_pkg::chip_manufacturing_state |-> &key_v_q[4:3];
  endproperty
  a_cm_exit: assert property (p_cm_exit) else $error("left manufacturing unprovisioned");
  c_regress_ok: cover property (reg_ok ##[1:20] resp_good);
  c_regress_bad: cover property (reg_ok ##[1:20] (resp_wr && !resp_good));
  c_erase: cover property (erase_ok);
  c_lockboot: cover property (adv_ok && tgt == lcag_pkg::locked_boot_state);
endmodule
`default_nettype wire

// [hw/lcag_pkg.sv]
// package of constants and types for the lifecycle access gate
package lcag_pkg;
  typedef enum logic [7:0] {
    chip_manufacturing_state = 8'h01,
    secure_dev_state = 8'h02,
    nonsecure_dev_state = 8'h04,
    deployed_state = 8'h08,
    locked_debug_state = 8'h10,
    locked_boot_state = 8'h20,
    return_request_state = 8'h40,
    return_ack_state = 8'h80
  } lcag_lc_type;
  typedef enum logic [1:0] {
    AU_IDLE = 2'h1,
    AU_WAIT = 2'h2
  } lcag_au_type;
  typedef struct packed {
    logic [1:0] dbg_level;
    logic dbg_conn;
    logic dbg_secure;
    logic sp_en;
    logic sp_sec_flash;
    logic sp_ns_flash;
  } lcag_acc_type;
  typedef struct packed {
    logic valid;
    logic flash;
    logic secure;
  } lcag_sp_req_type;
  localparam logic [1:0] DEBUG_NONE_LEVEL = 2'h0;
  localparam logic [1:0] DEBUG_NONSECURE_LEVEL = 2'h1;
  localparam logic [1:0] DEBUG_FULL_LEVEL = 2'h2;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_CHAL = 8'h0c;
  localparam logic [7:0] OFS_RESP = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [3:0] OP_ADVANCE = 4'h1;
  localparam logic [3:0] OP_REGRESS = 4'h2;
  localparam logic [3:0] OP_ERASE = 4'h3;
  localparam logic [3:0] OP_INJ_SDK = 4'h4;
  localparam logic [3:0] OP_INJ_NSDK = 4'h5;
  localparam logic [3:0] OP_INJ_RAK = 4'h6;
  localparam logic [3:0] OP_INJ_UID = 4'h7;
  localparam logic [3:0] OP_INJ_HUK = 4'h8;
  localparam int CMD_OP_POS = 0;
  localparam int CMD_TGT_POS = 8;
  localparam int ST_LC_POS = 0;
  localparam int ST_LVL_POS = 8;
  localparam int ST_KEYS_POS = 12;
  localparam int ST_BUSY_POS = 20;
  localparam int ST_LOADED_POS = 21;
  localparam int RES_OK_POS = 0;
  localparam int RES_BAD_POS = 1;
  localparam int RES_ERR_POS = 2;
  localparam logic [31:0] LFSR_SEED = 32'h1357_9bdf;
endpackage

// [verification/lcag_host_model.sv]
// model of the external debugger and serial programming host
`timescale 1ns/100ps
`default_nettype none
module lcag_host_model (
  input wire logic CLK,
  input wire logic [31:0] CHAL,
  input wire logic [31:0] KEY,
  output logic [31:0] RESP,
  output logic DBG_REQ,
  output lcag_pkg::lcag_sp_req_type SP_REQ
);
  // the host answers a challenge with the key that belongs to the target state
  assign RESP = CHAL ^ KEY;
  initial begin
    DBG_REQ = 1'b0;
    SP_REQ = '0;
  end
  task automatic dbg(input logic on);
    @(posedge CLK);
    DBG_REQ <= on;
  endtask
  // request is one cycle long; qualifiers drop with valid so stale bits never linger
  task automatic sp_send(input logic flash, input logic secure);
    @(posedge CLK);
    SP_REQ <= '{valid: 1'b1, flash: flash, secure: secure};
    @(posedge CLK);
    SP_REQ <= '0;
  endtask
endmodule
`default_nettype wire

// [verification/lifecycle_access_gate_tb_top.sv]
// self-checking bench for the lifecycle access gate
`timescale 1ns/100ps
`default_nettype none
module lifecycle_access_gate_tb_top;
  localparam logic [7:0] lc_tab [9] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h01, 8'h03, 8'h40,
    8'h80};
  // {level[1:0], conn, secure, sp_en, sec_flash, ns_flash}
  localparam logic [6:0] acc_tab [9] = '{7'h5f, 7'h35, 7'h04, 7'h04, 7'h00, 7'h5c, 7'h00, 7'h04,
    7'h5c};
  localparam logic [31:0] sdk = 32'h5a5a_1234;
  localparam logic [31:0] nsdk = 32'h0f0f_7777;
  localparam logic [31:0] rak = 32'h3c3c_9999;
  logic CLK;
  logic RESET_N;
  logic [7:0] ADDR;
  logic [31:0] WDATA;
  logic WR;
  logic RD;
  logic [31:0] RDATA;
  logic [7:0] nv_q;
  logic [7:0] nv_val;
  logic nv_ld;
  logic NV_WR;
  logic [7:0] NV_WDATA;
  logic FLASH_ERASE_ALL;
  logic DBG_REQ;
  logic DBG_GRANT;
  lcag_pkg::lcag_acc_type ACCESS;
  lcag_pkg::lcag_sp_req_type SP_REQ;
  logic SP_GRANT;
  logic SP_REJECT;
  logic [31:0] chal;
  logic [31:0] hkey;
  logic [31:0] resp;
  logic [31:0] v;
  logic g;
  int err_count;
  int total_checks;
  int cycles;

  lcag_gate lcag_gate_inst (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .NV_STATE(nv_q), .NV_WR(NV_WR), .NV_WDATA(NV_WDATA),
    .FLASH_ERASE_ALL(FLASH_ERASE_ALL), .DBG_REQ(DBG_REQ), .DBG_GRANT(DBG_GRANT),
    .ACCESS(ACCESS), .SP_REQ(SP_REQ), .SP_GRANT(SP_GRANT), .SP_REJECT(SP_REJECT));
  lcag_host_model lcag_host_model_inst (.CLK(CLK), .CHAL(chal), .KEY(hkey), .RESP(resp),
    .DBG_REQ(DBG_REQ), .SP_REQ(SP_REQ));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // non-volatile store follows every state write; the bench preloads it around a reset
  always @(posedge CLK) begin
    if (nv_ld) begin
      nv_q <= nv_val;
    end else if (NV_WR) begin
      nv_q <= NV_WDATA;
    end
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] tgt);
    wr(lcag_pkg::OFS_CMD, {16'h0000, tgt, 4'h0, op});
  endtask
  task automatic inj(input logic [3:0] op, input logic [31:0] key);
    wr(lcag_pkg::OFS_KEY, key);
    cmd(op, 8'h00);
  endtask
  task automatic rst(input logic [7:0] nv);
    @(posedge CLK);
    nv_val <= nv;
    nv_ld <= 1'b1;
    RESET_N <= 1'b0;
    repeat (3) @(posedge CLK);
    nv_ld <= 1'b0;
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  task automatic chk_st(input logic [7:0] lc, input logic [1:0] lvl);
    rd(lcag_pkg::OFS_STATUS, v);
    chk("lc", {24'h0, lc}, {24'h0, v[7:0]});
    chk("level", {30'h0, lvl}, {30'h0, v[9:8]});
  endtask
  task automatic chk_res(input logic [31:0] mask, input logic [31:0] exp);
    rd(lcag_pkg::OFS_RESULT, v);
    chk("result", exp, v & mask);
  endtask
  task automatic regress(input logic [7:0] tgt, input logic [31:0] key, input logic good);
    cmd(lcag_pkg::OP_REGRESS, tgt);
    rd(lcag_pkg::OFS_STATUS, v);
    chk("pending", 32'h1, {31'h0, v[lcag_pkg::ST_BUSY_POS]});
    rd(lcag_pkg::OFS_CHAL, chal);
    hkey = key;
    #1 wr(lcag_pkg::OFS_RESP, good ? resp : ~resp);
    chk_res(32'h3, good ? 32'h1 : 32'h2);
  endtask

  initial begin
    RESET_N = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    nv_ld = 1'b0;
    nv_val = 8'h02;
    chal = 32'h0;
    hkey = 32'h0;
    repeat (3) @(posedge CLK);
    // every state, the return states, and one corrupt code that must fail closed
    for (int i = 0; i < 9; i++) begin
      rst(lc_tab[i]);
      chk("access", {25'h0, acc_tab[i]}, {25'h0, ACCESS});
      lcag_host_model_inst.dbg(1'b1);
      repeat (3) @(posedge CLK);
      #1 chk("dbg_grant", {31'h0, acc_tab[i][4]}, {31'h0, DBG_GRANT});
      lcag_host_model_inst.dbg(1'b0);
      for (int k = 0; k < 3; k++) begin
        lcag_host_model_inst.sp_send(k != 0, k == 1);
        g = (k == 0) ? acc_tab[i][2] : ((k == 1) ? acc_tab[i][1] : acc_tab[i][0]);
        #1 chk("sp", {30'h0, g, ~g}, {30'h0, SP_GRANT, SP_REJECT});
      end
    end
    rst(8'h01);
    cmd(lcag_pkg::OP_ADVANCE, 8'h02);
    chk_res(32'h4, 32'h4);
    chk_st(8'h01, 2'h2);
    cmd(lcag_pkg::OP_INJ_UID, 8'h00);
    cmd(lcag_pkg::OP_INJ_HUK, 8'h00);
    cmd(lcag_pkg::OP_ADVANCE, 8'h02);
    #1 chk("nv_store", 32'h102, {23'h0, NV_WR, NV_WDATA});
    chk_st(8'h02, 2'h2);
    inj(lcag_pkg::OP_INJ_SDK, sdk);
    inj(lcag_pkg::OP_INJ_RAK, rak);
    inj(lcag_pkg::OP_INJ_NSDK, nsdk);
    chk_res(32'h4, 32'h4);
    rd(lcag_pkg::OFS_STATUS, v);
    chk("keys", 32'h1d, {27'h0, v[16:12]});
    cmd(lcag_pkg::OP_ADVANCE, 8'h04);
    chk_st(8'h04, 2'h1);
    inj(lcag_pkg::OP_INJ_SDK, sdk);
    chk_res(32'h4, 32'h4);
    inj(lcag_pkg::OP_INJ_NSDK, nsdk);
    chk_res(32'h4, 32'h0);
    regress(8'h02, sdk, 1'b0);
    chk_st(8'h04, 2'h1);
    regress(8'h02, sdk, 1'b1);
    chk_st(8'h02, 2'h2);
    cmd(lcag_pkg::OP_ADVANCE, 8'h08);
    cmd(lcag_pkg::OP_ADVANCE, 8'h04);
    chk_res(32'h4, 32'h4);
    chk_st(8'h08, 2'h0);
    regress(8'h04, nsdk, 1'b1);
    chk_st(8'h04, 2'h1);
    cmd(lcag_pkg::OP_ADVANCE, 8'h08);
    cmd(lcag_pkg::OP_ERASE, 8'h02);
    #1 chk("erase", 32'h1, {31'h0, FLASH_ERASE_ALL});
    chk_st(8'h02, 2'h2);
    // state must come back from the store, not from flops lost in reset
    rst(nv_q);
    chk_st(8'h02, 2'h2);
    rd(8'h20, v);
    chk("unmapped", 32'h0, v);
    end_sim();
  end
endmodule
`default_nettype wire
